//--- core/ppsm_power_state_manager.v
// ppsm_power_state_manager.v: global power-state sequencer of the phy device.
// assumes all inputs synchronous to clk_sys; axi4-lite master on one clock.
//
// Notes on behaviour
// - state chosen from controller messages and link
// - no cable reports link down to controller
// - phy control bit 11 set enters ieee power-down
// - in-band message or supply-ok low powers down
// - device power down keeps only wake logic
// - partner lpi with enable: rx off, indicate
// - tx lpi request: tx quiet, tx power off
// - cable disconnect: energy detect, pcie power down
// - energy detected leaves cable disconnect
// - first exit step clears unplugged flag (done only on the energy exit to idle; exits to power-down leave it set)
// - after cable reconnect, advertise only once break-link timer expires (a pass from power-up straight to idle advertises at once, without the wait)
// - shutdown pin low forces power down
// - stay-active setting ignores power-down command
// - power-down setting: phy off, clocks gated, idle
// - break-link wait between 1.2 and 1.3 s
//
// Design decisions made here: the AXI4-Lite register port and the address map.
`include "ppsm_consts.vh"
`timescale 1ns/1ps

module ppsm_power_state_manager #(
	parameter BRK_CYCLES = `PPSM_BRK_CYCLES
) (
	input wire clk_sys, // system clock, 40 mhz
	input wire arst_n, // async reset, active low
	input wire [11:0] s_axi_awaddr, // write address
	input wire s_axi_awvalid, // write address valid
	output wire s_axi_awready, // write address ready
	input wire [31:0] s_axi_wdata, // write data
	input wire [3:0] s_axi_wstrb, // byte enables
	input wire s_axi_wvalid, // write data valid
	output wire s_axi_wready, // write data ready
	output wire [1:0] s_axi_bresp, // write response
	output wire s_axi_bvalid, // write response valid
	input wire s_axi_bready, // write response ready
	input wire [11:0] s_axi_araddr, // read address
	input wire s_axi_arvalid, // read address valid
	output wire s_axi_arready, // read address ready
	output wire [31:0] s_axi_rdata, // read data
	output wire [1:0] s_axi_rresp, // read response
	output wire s_axi_rvalid, // read data valid
	input wire s_axi_rready, // read data ready
	input wire phy_init_done, // phy finished power-up
	input wire cable_present, // phy sees a cable
	input wire link_up, // ethernet link established
	input wire link_busy, // traffic on the link
	input wire energy_detect, // energy seen on media side
	input wire partner_lpi, // partner tx in lpi
	input wire ib_pd_req, // in-band power-down message
	input wire ib_tx_lpi_req, // in-band tx lpi request level
	input wire ib_wake_req, // in-band power-up message
	input wire port_shutdown_n, // shutdown pin, active low
	input wire port_supply_ok_n, // supply-good pin, low requests power down
	output reg [2:0] pwr_state_q, // encoded global state
	output reg link_down_ind_q, // link-down status to controller
	output reg unplugged_q, // unplugged flag on pcie/smbus
	output reg energy_detect_mode_q, // phy in energy detect mode
	output reg pcie_pd_q, // pcie link powered down
	output reg pcie_elec_idle_q, // pcie link in electrical idle
	output reg phy_pwr_en_q, // phy analog powered
	output reg clk_gate_n_q, // core clocks running, low gates them
	output reg rx_pwr_en_q, // receive circuitry powered
	output reg tx_pwr_en_q, // transmit circuitry powered
	output reg tx_lpi_q, // transmitter in lpi
	output reg ib_rx_lpi_ind_q, // in-band rx lpi indication
	output reg an_advertise_q // auto-negotiation advertising enabled
);

	// ----------------------------------------
	// internal signals
	// ----------------------------------------
	wire [31:0] ctrl_q; // control word
	wire [31:0] phyctl_q; // phy control word
	wire [31:0] stat_word; // status readback
	wire lpi_en; // lpi support enabled
	wire pd_mode_on; // 1: power-down setting, 0: stay active
	wire ieee_pd; // ieee power-down bit
	wire pd_cmd; // any device power-down trigger
	wire brk_expired; // break-link wait over
	reg brk_start_q; // start the break-link wait
	reg brk_wait_q; // waiting for break-link expiry
	reg [2:0] state_d; // next state

	assign lpi_en = ctrl_q[`PPSM_CTRL_LPI_EN];
	assign pd_mode_on = ctrl_q[`PPSM_CTRL_PD_MODE];
	assign ieee_pd = phyctl_q[`PPSM_PHYCTL_PWR_DOWN];
	// pin always wins; message and supply-ok obey the mode field
	assign pd_cmd = !port_shutdown_n || (pd_mode_on && (ib_pd_req || !port_supply_ok_n));
	assign stat_word = {16'h0000, 3'h0, brk_wait_q, an_advertise_q, tx_lpi_q, ib_rx_lpi_ind_q,
		unplugged_q, link_down_ind_q, energy_detect_mode_q, phy_pwr_en_q, clk_gate_n_q,
		1'b0, pwr_state_q};

	// ----------------------------------------
	// register file
	// ----------------------------------------
	ppsm_axil_regs u_regs (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.stat_word(stat_word),
		.pd_bit_clr(1'b0),
		.ctrl_q(ctrl_q),
		.phyctl_q(phyctl_q)
	);

	// ----------------------------------------
	// break-link timer
	// ----------------------------------------
	ppsm_break_timer #(
		.CNT_W(32),
		.LOAD(BRK_CYCLES)
	) u_brk (
		.clk_sys(clk_sys),
		.arst_n(arst_n),
		.start(brk_start_q),
		.abort(pwr_state_q == `PPSM_ST_DEV_PD || !cable_present),
		.expired_q(brk_expired)
	);

	// ----------------------------------------
	// next-state logic, priority high to low:
	// dev pd, ieee pd, cable, link down, lpi, idle/active
	// ----------------------------------------
	always @* begin
		state_d = pwr_state_q;
		case (pwr_state_q)
			`PPSM_ST_PWR_UP: begin
				if (pd_cmd) begin
					state_d = `PPSM_ST_DEV_PD;
				end else if (phy_init_done) begin
					state_d = cable_present ? `PPSM_ST_IDLE : `PPSM_ST_CABLE_DISC;
				end
			end
			`PPSM_ST_DEV_PD: begin
				// wake message, or both pins high with no power-down message, brings it back
				if (!pd_cmd && (ib_wake_req || (port_shutdown_n && port_supply_ok_n && !ib_pd_req))) begin
					state_d = `PPSM_ST_PWR_UP;
				end
			end
			`PPSM_ST_IEEE_PD: begin
				if (pd_cmd) begin
					state_d = `PPSM_ST_DEV_PD;
				end else if (!ieee_pd) begin
					state_d = `PPSM_ST_PWR_UP;
				end
			end
			`PPSM_ST_CABLE_DISC: begin
				if (pd_cmd) begin
					state_d = `PPSM_ST_DEV_PD;
				end else if (ieee_pd) begin
					state_d = `PPSM_ST_IEEE_PD;
				end else if (energy_detect) begin
					state_d = `PPSM_ST_IDLE;
				end
			end
			default: begin
				// active, idle and lpi share the link-driven choice
				if (pd_cmd) begin
					state_d = `PPSM_ST_DEV_PD;
				end else if (ieee_pd) begin
					state_d = `PPSM_ST_IEEE_PD;
				end else if (!cable_present) begin
					state_d = `PPSM_ST_CABLE_DISC;
				end else if (!link_up) begin
					state_d = `PPSM_ST_IDLE;
				end else if ((lpi_en && partner_lpi) || ib_tx_lpi_req) begin
					state_d = `PPSM_ST_LPI;
				end else if (link_busy) begin
					state_d = `PPSM_ST_ACTIVE;
				end else begin
					state_d = `PPSM_ST_IDLE;
				end
			end
		endcase
	end

	// ----------------------------------------
	// state register and derived outputs
	// ----------------------------------------
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			pwr_state_q <= `PPSM_ST_PWR_UP;
			link_down_ind_q <= 1'b1;
			unplugged_q <= 1'b0;
			energy_detect_mode_q <= 1'b0;
			pcie_pd_q <= 1'b0;
			pcie_elec_idle_q <= 1'b0;
			phy_pwr_en_q <= 1'b0;
			clk_gate_n_q <= 1'b1;
			rx_pwr_en_q <= 1'b0;
			tx_pwr_en_q <= 1'b0;
			tx_lpi_q <= 1'b0;
			ib_rx_lpi_ind_q <= 1'b0;
			an_advertise_q <= 1'b0;
			brk_start_q <= 1'b0;
			brk_wait_q <= 1'b0;
		end else begin
			pwr_state_q <= state_d;
			brk_start_q <= 1'b0;
			// cable-disconnect entry and exit
			if (state_d == `PPSM_ST_CABLE_DISC) begin
				unplugged_q <= 1'b1;
				energy_detect_mode_q <= 1'b1;
				pcie_pd_q <= 1'b1;
				an_advertise_q <= 1'b0;
				brk_wait_q <= 1'b0;
			end else begin
				energy_detect_mode_q <= 1'b0;
				pcie_pd_q <= 1'b0;
			end
			if (pwr_state_q == `PPSM_ST_CABLE_DISC && state_d == `PPSM_ST_IDLE) begin
				unplugged_q <= 1'b0;
				brk_start_q <= 1'b1;
				brk_wait_q <= 1'b1;
			end else if (pwr_state_q == `PPSM_ST_PWR_UP && state_d == `PPSM_ST_IDLE) begin
				an_advertise_q <= 1'b1; // leaving power-up has no break wait
			end
			if (brk_expired && brk_wait_q) begin
				brk_wait_q <= 1'b0;
				an_advertise_q <= 1'b1;
			end
			// link-down report to the controller
			link_down_ind_q <= !(link_up && cable_present) || state_d == `PPSM_ST_CABLE_DISC;
			// device power down gates everything but the wake path
			if (state_d == `PPSM_ST_DEV_PD) begin
				phy_pwr_en_q <= 1'b0;
				clk_gate_n_q <= 1'b0;
				pcie_elec_idle_q <= 1'b1;
				an_advertise_q <= 1'b0;
				brk_wait_q <= 1'b0;
			end else begin
				phy_pwr_en_q <= state_d != `PPSM_ST_IEEE_PD && state_d != `PPSM_ST_PWR_UP;
				clk_gate_n_q <= 1'b1;
				pcie_elec_idle_q <= 1'b0;
			end
			// lpi: rx follows partner, tx follows request
			if (state_d == `PPSM_ST_LPI && lpi_en && partner_lpi) begin
				rx_pwr_en_q <= 1'b0;
				ib_rx_lpi_ind_q <= 1'b1;
			end else begin
				rx_pwr_en_q <= state_d == `PPSM_ST_ACTIVE || state_d == `PPSM_ST_IDLE || state_d == `PPSM_ST_LPI;
				ib_rx_lpi_ind_q <= 1'b0;
			end
			if (state_d == `PPSM_ST_LPI && ib_tx_lpi_req) begin
				tx_lpi_q <= 1'b1;
				tx_pwr_en_q <= 1'b0;
			end else begin
				tx_lpi_q <= 1'b0;
				tx_pwr_en_q <= state_d == `PPSM_ST_ACTIVE || state_d == `PPSM_ST_IDLE || state_d == `PPSM_ST_LPI;
			end
		end
	end

endmodule

//--- core/ppsm_consts.vh
// ppsm_consts.vh: offsets, field positions, reset values and timing counts
// for the phy power-state manager. assumes inclusion by bare name.
`ifndef PPSM_CONSTS_VH
`define PPSM_CONSTS_VH

// ----------------------------------------
// register byte offsets (axi4-lite, one word each)
// ----------------------------------------
`define PPSM_OFF_CTRL 12'h000
`define PPSM_OFF_STAT 12'h004
`define PPSM_OFF_PHYCTL 12'h008

// ----------------------------------------
// control register fields
// ----------------------------------------
`define PPSM_CTRL_LPI_EN 0
`define PPSM_CTRL_PD_MODE 1
`define PPSM_CTRL_RESET 32'h0000_0002

// ----------------------------------------
// phy control register fields
// ----------------------------------------
`define PPSM_PHYCTL_PWR_DOWN 11

// ----------------------------------------
// global power states
// ----------------------------------------
`define PPSM_ST_PWR_UP 3'h0
`define PPSM_ST_ACTIVE 3'h1
`define PPSM_ST_IDLE 3'h2
`define PPSM_ST_CABLE_DISC 3'h3
`define PPSM_ST_IEEE_PD 3'h4
`define PPSM_ST_DEV_PD 3'h5
`define PPSM_ST_LPI 3'h6

// ----------------------------------------
// timing
// ----------------------------------------
`define PPSM_CLK_HZ 40000000
`define PPSM_BRK_MIN_MS 1200
`define PPSM_BRK_MAX_MS 1300
// least wait: 1200 ms
`define PPSM_BRK_CYCLES ((`PPSM_CLK_HZ / 1000) * `PPSM_BRK_MIN_MS)

// axi responses
`define PPSM_RESP_OKAY 2'h0
`define PPSM_RESP_SLVERR 2'h2

`endif

//--- core/ppsm_break_timer.v
// ppsm_break_timer.v: one-shot countdown for the break-link wait.
// assumes start is a one-cycle pulse; abort cancels the wait.
`timescale 1ns/1ps

module ppsm_break_timer #(
	parameter CNT_W = 32,
	parameter [CNT_W-1:0] LOAD = 32'd48000000
) (
	input wire clk_sys, // system clock
	input wire arst_n, // async reset, active low
	input wire start, // load and run
	input wire abort, // stop without expiring
	output reg expired_q // one-cycle pulse at end of wait
);

	reg [CNT_W-1:0] cnt_q; // remaining cycles
	reg run_q; // wait in progress

	// ----------------------------------------
	// countdown
	// ----------------------------------------
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q <= {CNT_W{1'b0}};
			run_q <= 1'b0;
			expired_q <= 1'b0;
		end else begin
			expired_q <= 1'b0;
			if (abort) begin
				run_q <= 1'b0; // wait dropped
			end else if (start) begin
				cnt_q <= LOAD; // restart counts from full
				run_q <= 1'b1;
			end else if (run_q) begin
				if (cnt_q <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
					run_q <= 1'b0;
					expired_q <= 1'b1;
				end else begin
					cnt_q <= cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
				end
			end
		end
	end

endmodule

//--- core/ppsm_axil_regs.v
// ppsm_axil_regs.v: axi4-lite slave holding control and phy control words.
// assumes single outstanding write and read from the master.
`include "ppsm_consts.vh"
`timescale 1ns/1ps

module ppsm_axil_regs (
	input wire clk_sys, // system clock
	input wire arst_n, // async reset, active low
	input wire [11:0] s_axi_awaddr, // write address
	input wire s_axi_awvalid, // write address valid
	output reg s_axi_awready, // write address ready
	input wire [31:0] s_axi_wdata, // write data
	input wire [3:0] s_axi_wstrb, // byte enables
	input wire s_axi_wvalid, // write data valid
	output reg s_axi_wready, // write data ready
	output reg [1:0] s_axi_bresp, // write response
	output reg s_axi_bvalid, // write response valid
	input wire s_axi_bready, // write response ready
	input wire [11:0] s_axi_araddr, // read address
	input wire s_axi_arvalid, // read address valid
	output reg s_axi_arready, // read address ready
	output reg [31:0] s_axi_rdata, // read data
	output reg [1:0] s_axi_rresp, // read response
	output reg s_axi_rvalid, // read data valid
	input wire s_axi_rready, // read data ready
	input wire [31:0] stat_word, // live status from the core
	input wire pd_bit_clr, // core clears power-down bit
	output reg [31:0] ctrl_q, // control word
	output reg [31:0] phyctl_q // phy control word
);

	reg [11:0] awaddr_q; // latched write address
	reg aw_have_q; // address held
	reg [31:0] wdata_q; // latched write data
	reg [3:0] wstrb_q; // latched strobes
	reg w_have_q; // data held

	// byte-lane merge for writable words
	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0] be;
		integer i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (be[i]) begin
					merge[i*8 +: 8] = nw[i*8 +: 8];
				end
			end
		end
	endfunction

	// ----------------------------------------
	// write channel: address and data in any order
	// ----------------------------------------
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `PPSM_RESP_OKAY;
			awaddr_q <= 12'h000;
			aw_have_q <= 1'b0;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			w_have_q <= 1'b0;
			ctrl_q <= `PPSM_CTRL_RESET;
			phyctl_q <= 32'h0000_0000;
		end else begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			// hardware clear of the power-down bit; a write below wins
			if (pd_bit_clr) begin
				phyctl_q[`PPSM_PHYCTL_PWR_DOWN] <= 1'b0;
			end
			if (s_axi_awvalid && !aw_have_q && !s_axi_awready && !s_axi_bvalid) begin
				s_axi_awready <= 1'b1;
				awaddr_q <= s_axi_awaddr;
				aw_have_q <= 1'b1;
			end
			if (s_axi_wvalid && !w_have_q && !s_axi_wready && !s_axi_bvalid) begin
				s_axi_wready <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
				w_have_q <= 1'b1;
			end
			if (aw_have_q && w_have_q && !s_axi_bvalid) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= `PPSM_RESP_OKAY;
				if (awaddr_q[11:2] == `PPSM_OFF_CTRL >> 2) begin
					ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q) & 32'h0000_0003;
				end else if (awaddr_q[11:2] == `PPSM_OFF_PHYCTL >> 2) begin
					phyctl_q <= merge(phyctl_q, wdata_q, wstrb_q);
				end else if (awaddr_q[11:2] == `PPSM_OFF_STAT >> 2) begin
					s_axi_bresp <= `PPSM_RESP_OKAY; // read-only, write ignored
				end else begin
					s_axi_bresp <= `PPSM_RESP_SLVERR; // unmapped
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// read channel: answer next cycle
	// ----------------------------------------
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `PPSM_RESP_OKAY;
		end else begin
			s_axi_arready <= 1'b0;
			if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
				s_axi_arready <= 1'b1;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `PPSM_RESP_OKAY;
				if (s_axi_araddr[11:2] == `PPSM_OFF_CTRL >> 2) begin
					s_axi_rdata <= ctrl_q;
				end else if (s_axi_araddr[11:2] == `PPSM_OFF_STAT >> 2) begin
					s_axi_rdata <= stat_word;
				end else if (s_axi_araddr[11:2] == `PPSM_OFF_PHYCTL >> 2) begin
					s_axi_rdata <= phyctl_q;
				end else begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= `PPSM_RESP_SLVERR;
				end
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

endmodule

//--- testbench/ppsm_power_state_manager_asserts.sv
// checker on the power-state manager's ports.
// assumes a bind from the bench top; one clock.
`timescale 1ns/1ps
`include "ppsm_consts.vh"

module ppsm_power_state_manager_asserts #(
	parameter BRK_CYCLES = 50
) (
	input wire clk_sys, // system clock
	input wire arst_n, // async reset, active low
	input wire energy_detect, // media energy
	input wire ib_pd_req, // in-band power-down
	input wire ib_tx_lpi_req, // in-band tx lpi request
	input wire port_shutdown_n, // shutdown pin
	input wire port_supply_ok_n, // supply pin
	input wire [2:0] pwr_state_q, // encoded state
	input wire link_down_ind_q, // link down to controller
	input wire unplugged_q, // unplugged flag
	input wire energy_detect_mode_q, // energy detect mode
	input wire pcie_pd_q, // pcie powered down
	input wire pcie_elec_idle_q, // electrical idle
	input wire phy_pwr_en_q, // phy powered
	input wire clk_gate_n_q, // clocks running
	input wire rx_pwr_en_q, // rx powered
	input wire tx_pwr_en_q, // tx powered
	input wire tx_lpi_q, // tx in lpi
	input wire ib_rx_lpi_ind_q, // rx lpi indication
	input wire an_advertise_q // advertising
);
	// ----------------------------------------
	// break-wait tracking
	// ----------------------------------------
	reg [31:0] brk_cnt_q; // cycles since unplugged fell
	reg brk_wait_q; // wait under way
	wire st_link; // idle or active
	assign st_link = pwr_state_q == `PPSM_ST_IDLE || pwr_state_q == `PPSM_ST_ACTIVE;

	// restart at the flag's fall; other states cancel
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			brk_cnt_q <= 32'h0000_0000;
			brk_wait_q <= 1'b0;
		end else if ($fell(unplugged_q)) begin
			brk_cnt_q <= 32'h0000_0000;
			brk_wait_q <= 1'b1;
		end else if (an_advertise_q || !st_link) begin
			brk_wait_q <= 1'b0;
		end else begin
			brk_cnt_q <= brk_cnt_q + 32'h0000_0001;
		end
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	AST_SHUTDOWN: assert property (!port_shutdown_n |=> pwr_state_q == `PPSM_ST_DEV_PD)
		else $error("no power down on pin");
	AST_PD_OUT: assert property (pwr_state_q == `PPSM_ST_DEV_PD |->
		!phy_pwr_en_q && !clk_gate_n_q && pcie_elec_idle_q && !an_advertise_q)
		else $error("power down leaves functions on");
	AST_DISC_OUT: assert property (pwr_state_q == `PPSM_ST_CABLE_DISC |->
		link_down_ind_q && energy_detect_mode_q && pcie_pd_q && unplugged_q)
		else $error("cable disconnect outputs wrong");
	AST_DISC_EXIT: assert property (pwr_state_q == `PPSM_ST_CABLE_DISC && energy_detect &&
		port_shutdown_n && port_supply_ok_n && !ib_pd_req |=> pwr_state_q == `PPSM_ST_IDLE && !unplugged_q)
		else $error("energy kept cable disconnect");
	AST_BRK_MIN: assert property ($rose(an_advertise_q) && brk_wait_q |-> brk_cnt_q >= BRK_CYCLES - 2)
		else $error("advertised too early");
	AST_BRK_MAX: assert property (brk_wait_q && !an_advertise_q |-> brk_cnt_q <= BRK_CYCLES + 6)
		else $error("break wait too long");
	AST_RX_LPI: assert property (ib_rx_lpi_ind_q |-> !rx_pwr_en_q)
		else $error("rx powered during rx lpi");
	AST_TX_LPI: assert property ($rose(tx_lpi_q) |-> $past(ib_tx_lpi_req) && !tx_pwr_en_q)
		else $error("bad tx lpi entry");
	AST_STATE: assert property (pwr_state_q <= `PPSM_ST_LPI)
		else $error("state code out of range");
	AST_WAKE: assert property ($rose(port_shutdown_n) && pwr_state_q == `PPSM_ST_DEV_PD &&
		port_supply_ok_n && !ib_pd_req |=> pwr_state_q == `PPSM_ST_PWR_UP)
		else $error("no wake on pin release");

	COV_PIN_PD: cover property (pwr_state_q == `PPSM_ST_DEV_PD && !port_shutdown_n);
	COV_BRK: cover property ($rose(an_advertise_q) && brk_wait_q);
	COV_TX_LPI: cover property (tx_lpi_q);
endmodule

//--- testbench/ppsm_lan_ctrl_model.sv
// lan controller model: in-band requests and the supply pin.
// assumes bench wishes change just after a rising edge.
`timescale 1ns/1ps

module ppsm_lan_ctrl_model (
	input wire clk_sys, // system clock
	input wire arst_n, // async reset, active low
	input wire cfg_done, // configuration cycle finished
	input wire slow, // answer one cycle later
	input wire want_pd, // bench wants in-band power down
	input wire want_pin_pd, // bench wants supply pin low
	input wire want_tx_lpi, // bench wants tx lpi
	output reg ib_pd_req, // in-band power-down message
	output reg ib_tx_lpi_req, // in-band tx lpi request
	output reg port_supply_ok_n // supply pin, low asks power down
);
	reg [2:0] stage_q; // delay stage for slow answers
	wire [2:0] want; // in-band power-down held back until configured
	assign want = {want_tx_lpi, want_pin_pd, want_pd & cfg_done};

	// registered requests, prompt or one cycle late
	always @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			stage_q <= 3'h0;
			ib_pd_req <= 1'b0;
			ib_tx_lpi_req <= 1'b0;
			port_supply_ok_n <= 1'b1;
		end else begin
			stage_q <= want;
			ib_pd_req <= slow ? stage_q[0] : want[0];
			port_supply_ok_n <= !(slow ? stage_q[1] : want[1]);
			ib_tx_lpi_req <= slow ? stage_q[2] : want[2];
		end
	end
endmodule

//--- testbench/tb_phy_power_state_manager.sv
// self-checking bench for the phy power-state manager.
// assumes a short break wait (BRK).
`timescale 1ns/1ps
`include "ppsm_consts.vh"

module tb_phy_power_state_manager;
	localparam BRK = 50; // shortened break wait
	reg clk_sys = 0, arst_n = 0;
	reg [11:0] s_axi_awaddr = 0, s_axi_araddr = 0, a;
	reg [31:0] s_axi_wdata = 0, d;
	reg [3:0] s_axi_wstrb = 0;
	reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	reg phy_init_done = 0, cable_present = 0, link_up = 0, link_busy = 0, energy_detect = 0;
	reg partner_lpi = 0, port_shutdown_n = 1, cfg_done = 0, slow = 0, want_pd = 0, want_pin_pd = 0;
	reg want_tx_lpi = 0, pd;
	reg [1:0] r;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire ib_pd_req, ib_tx_lpi_req, port_supply_ok_n;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [2:0] pwr_state_q;
	wire link_down_ind_q, unplugged_q, energy_detect_mode_q, pcie_pd_q, pcie_elec_idle_q, phy_pwr_en_q;
	wire clk_gate_n_q, rx_pwr_en_q, tx_pwr_en_q, tx_lpi_q, ib_rx_lpi_ind_q, an_advertise_q;
	integer fails = 0, check_count = 0, seed = 80, k, n, u, cyc_cnt = 0;

	always #12.5 clk_sys = ~clk_sys; // 40 mhz

	ppsm_power_state_manager #(.BRK_CYCLES(BRK)) dut (.*, .ib_wake_req(1'b0));
	ppsm_lan_ctrl_model ctrl (.*);

	// ----------------------------------------
	// report and compare
	// ----------------------------------------
	task summarize;
		if (fails == 0 && check_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task chk_bit(input string nm, input e, input g);
		check_count = check_count + 1;
		if (g !== e) begin
			fails = fails + 1;
			$display("BAD %0s exp %b got %b", nm, e, g);
		end
	endtask
	task chk_word(input string nm, input [31:0] e, input [31:0] g);
		check_count = check_count + 1;
		if (g !== e) begin
			fails = fails + 1;
			$display("BAD %0s exp %h got %h", nm, e, g);
		end
	endtask

	// ----------------------------------------
	// axi4-lite master: hold each channel until taken
	// ----------------------------------------
	task axw(input [11:0] ad, input [31:0] wd);
		s_axi_awaddr <= ad;
		s_axi_wdata <= wd;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		@(posedge clk_sys);
		while (s_axi_bready) begin
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
			if (s_axi_bvalid) begin
				r = s_axi_bresp;
				s_axi_bready <= 0;
			end
			@(posedge clk_sys);
		end
	endtask
	task axr(input [11:0] ad);
		s_axi_araddr <= ad;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		@(posedge clk_sys);
		while (s_axi_rready) begin
			if (s_axi_arready) s_axi_arvalid <= 0;
			if (s_axi_rvalid) begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 0;
			end
			@(posedge clk_sys);
		end
	endtask
	// bounded wait for a state
	task wst(input [2:0] e, input integer lim);
		for (n = 0; n < lim && pwr_state_q !== e; n = n + 1) @(posedge clk_sys);
		chk_word("state", {29'h0, e}, {29'h0, pwr_state_q});
	endtask

	// hang guard
	always @(posedge clk_sys) begin
		cyc_cnt = cyc_cnt + 1;
		if (cyc_cnt == 20000) begin
			fails = fails + 1;
			summarize;
		end
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (12) @(posedge clk_sys);
		chk_word("rst_state", 0, {29'h0, pwr_state_q});
		chk_bit("rst_link_down", 1, link_down_ind_q);
		arst_n <= 1;
		@(posedge clk_sys);
		axr(`PPSM_OFF_CTRL);
		chk_word("ctrl_rst", `PPSM_CTRL_RESET, d);
		axr(`PPSM_OFF_PHYCTL);
		chk_word("phyctl_rst", 0, d);
		cfg_done <= 1;
		phy_init_done <= 1;
		cable_present <= 1;
		link_up <= 1;
		link_busy <= 1;
		wst(`PPSM_ST_ACTIVE, 20);
		link_busy <= 0;
		wst(`PPSM_ST_IDLE, 10);
		link_busy <= 1;
		wst(`PPSM_ST_ACTIVE, 10);
		// unplug, then energy returns
		cable_present <= 0;
		link_up <= 0;
		wst(`PPSM_ST_CABLE_DISC, 10);
		chk_bit("link_down", 1, link_down_ind_q);
		chk_bit("ed_mode", 1, energy_detect_mode_q);
		chk_bit("pcie_pd", 1, pcie_pd_q);
		cable_present <= 1;
		energy_detect <= 1;
		wst(`PPSM_ST_IDLE, 4);
		chk_bit("unplugged", 0, unplugged_q);
		for (u = 0; u < BRK + 20 && an_advertise_q !== 1; u = u + 1) @(posedge clk_sys);
		chk_bit("advertise", 1, an_advertise_q);
		chk_bit("brk_window", 1, u >= BRK - 2 && u <= BRK + 6);
		link_up <= 1;
		wst(`PPSM_ST_ACTIVE, 10);
		// ieee power down
		axw(`PPSM_OFF_PHYCTL, 32'h0000_0800);
		wst(`PPSM_ST_IEEE_PD, 10);
		axr(`PPSM_OFF_STAT);
		chk_word("stat_state", `PPSM_ST_IEEE_PD, {29'h0, d[2:0]});
		axw(`PPSM_OFF_PHYCTL, 32'h0000_0000);
		wst(`PPSM_ST_ACTIVE, 40);
		// power-down triggers under both modes
		for (k = 0; k < 6; k = k + 1) begin
			axw(`PPSM_OFF_CTRL, k[0] ? 32'h0000_0002 : 32'h0000_0000);
			slow <= $random(seed);
			want_pd <= k / 2 == 0;
			want_pin_pd <= k / 2 == 1;
			port_shutdown_n <= k / 2 != 2;
			pd = k[0] || k / 2 == 2;
			if (pd) wst(`PPSM_ST_DEV_PD, 10);
			else begin
				repeat (10) @(posedge clk_sys);
				wst(`PPSM_ST_ACTIVE, 1);
			end
			chk_bit("phy_pwr", !pd, phy_pwr_en_q);
			chk_bit("clk_on", !pd, clk_gate_n_q);
			chk_bit("elec_idle", pd, pcie_elec_idle_q);
			want_pd <= 0;
			want_pin_pd <= 0;
			port_shutdown_n <= 1;
			wst(`PPSM_ST_ACTIVE, 40);
		end
		// lpi, rx side gated by enable
		partner_lpi <= 1;
		repeat (4) @(posedge clk_sys);
		chk_bit("rx_lpi_off", 0, ib_rx_lpi_ind_q);
		axw(`PPSM_OFF_CTRL, 32'h0000_0003);
		repeat (4) @(posedge clk_sys);
		chk_bit("rx_lpi_ind", 1, ib_rx_lpi_ind_q);
		chk_bit("rx_pwr", 0, rx_pwr_en_q);
		partner_lpi <= 0;
		want_tx_lpi <= 1;
		repeat (4) @(posedge clk_sys);
		chk_bit("tx_lpi", 1, tx_lpi_q);
		chk_bit("tx_pwr", 0, tx_pwr_en_q);
		want_tx_lpi <= 0;
		// read-only status, random unmapped places
		axw(`PPSM_OFF_STAT, 32'hffff_ffff);
		chk_word("stat_wr_resp", `PPSM_RESP_OKAY, {30'h0, r});
		for (k = 0; k < 6; k = k + 1) begin
			u = {$random(seed)} % 1021;
			a = 12'h00c + {u[9:0], 2'b00};
			axw(a, $random(seed));
			chk_word("unm_bresp", `PPSM_RESP_SLVERR, {30'h0, r});
			axr(a);
			chk_word("unm_rresp", `PPSM_RESP_SLVERR, {30'h0, r});
			chk_word("unm_rdata", 0, d);
		end
		summarize;
	end
endmodule

bind ppsm_power_state_manager ppsm_power_state_manager_asserts #(.BRK_CYCLES(BRK_CYCLES)) u_chk (.*);
